// *** design/pio_map.vh ***
// Constants for the identity loader and strap mode logic.
// Included by the top-level design file only; definitions only.
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
`define PIO_SHIFT_LEN      33
`define PIO_CNT_W          6
`define PIO_WORD_W         16
`define PIO_NIB_W          4
// Strap decode, {test_strap_n, pull_disable_strap_n}
`define PIO_MODE_COPY      2'b11
`define PIO_MODE_NOCOPY    2'b10
`define PIO_MODE_SCAN      2'b01
`define PIO_MODE_IDDQ      2'b00
// Serial frame field positions
`define PIO_SMW_LSB        0
`define PIO_SPW_LSB        16
`define PIO_EXTRA_BIT      32
// TAP states
`define PIO_TAP_RESET      4'h0
`define PIO_TAP_IDLE       4'h1
`define PIO_TAP_SEL_DR     4'h2
`define PIO_TAP_CAP_DR     4'h3
`define PIO_TAP_SH_DR      4'h4
`define PIO_TAP_EX1_DR     4'h5
`define PIO_TAP_PAU_DR     4'h6
`define PIO_TAP_EX2_DR     4'h7
`define PIO_TAP_UPD_DR     4'h8
`define PIO_TAP_SEL_IR     4'h9
`define PIO_TAP_CAP_IR     4'hA
`define PIO_TAP_SH_IR      4'hB
`define PIO_TAP_EX1_IR     4'hC
`define PIO_TAP_PAU_IR     4'hD
`define PIO_TAP_EX2_IR     4'hE
`define PIO_TAP_UPD_IR     4'hF
`define PIO_IR_W           4
`define PIO_IR_CAPTURE     4'h1
`endif

// *** design/pio_sync.v ***
// Two flip-flop level synchroniser for a pin into the system clock.
// Assumes the reset given is already synchronous to the clock.
`timescale 1ns/1ps
module pio_sync #(
   parameter RST_VAL = 1'b0
) (
   input  wire i_clk,
   input  wire i_rst_n,
   input  wire i_pin,
   output reg  o_level
);
   reg stage1;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1  <= RST_VAL;
         o_level <= RST_VAL;
      end else begin
         stage1  <= i_pin;
         o_level <= stage1;
      end
   end
endmodule

// *** design/pio_top.v ***
// Identity word serial loader, strap mode decode, sequencer hold and
// a minimal boundary-scan TAP.
// Assumes serial data and strobe arrive on pins, and the PCI target
// logic outside honours o_target_retry. TAP runs on its own pins.
`timescale 1ns/1ps
`include "pio_map.vh"
module pio_top #(
   parameter [15:0] BUILTIN_MAKER = 16'h1234, // Arbitrary value
   parameter [3:0]  BUILTIN_NIB   = 4'hA       // Arbitrary value
) (
   input  wire        i_sys_clk,
   input  wire        i_arst_n,
   input  wire        i_test_strap_n,
   input  wire        i_pull_disable_strap_n,
   input  wire        i_serial_identity_input,
   input  wire        i_serial_clock,
   input  wire        i_serial_load_active,
   input  wire        i_sequencer_hold_n,
   input  wire        i_tck,
   input  wire        i_tms,
   input  wire        i_tdi,
   input  wire        i_trst_n,
   output reg  [15:0] o_maker_word,
   output reg  [15:0] o_subsystem_maker_word,
   output reg  [15:0] o_subsystem_part_word,
   output reg  [3:0]  o_part_nibble,
   output reg         o_target_retry,
   output reg         o_sequencer_pause,
   output reg         o_identity_copy_enable,
   output reg         o_scan_mode,
   output reg         o_iddq_mode,
   output reg         o_tdo
);
   reg rst_s1;
   reg rst_n;
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   wire test_s;
   wire pull_s;
   wire sdat_s;
   wire sclk_s;
   wire sact_s;
   wire hold_s;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire trst_s;
   // Every pin passes two flops; reset levels match the idle pin
   // levels except TRST, which resets low; no false edge is seen after reset.
   pio_sync #(
      .RST_VAL(1'b1)
   ) u_test (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_test_strap_n),
      .o_level (test_s)
   );

   pio_sync #(
      .RST_VAL(1'b1)
   ) u_pull (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_pull_disable_strap_n),
      .o_level (pull_s)
   );

   pio_sync #(
      .RST_VAL(1'b0)
   ) u_sdat (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_serial_identity_input),
      .o_level (sdat_s)
   );

   pio_sync #(
      .RST_VAL(1'b0)
   ) u_sclk (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_serial_clock),
      .o_level (sclk_s)
   );

   pio_sync #(
      .RST_VAL(1'b0)
   ) u_sact (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_serial_load_active),
      .o_level (sact_s)
   );

   pio_sync #(
      .RST_VAL(1'b1)
   ) u_hold (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_sequencer_hold_n),
      .o_level (hold_s)
   );

   pio_sync #(
      .RST_VAL(1'b0)
   ) u_tck (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_tck),
      .o_level (tck_s)
   );

   pio_sync #(
      .RST_VAL(1'b1)
   ) u_tms (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_tms),
      .o_level (tms_s)
   );

   pio_sync #(
      .RST_VAL(1'b0)
   ) u_tdi (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_tdi),
      .o_level (tdi_s)
   );

   pio_sync #(
      .RST_VAL(1'b0)
   ) u_trst (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_trst_n),
      .o_level (trst_s)
   );

   // Mode decode from the synchronised straps
   wire [1:0] straps = {test_s, pull_s};
   wire copy_en = (straps == `PIO_MODE_COPY);
   wire scan_m  = (straps == `PIO_MODE_SCAN);
   wire iddq_m  = (straps == `PIO_MODE_IDDQ);

   // Serial shifter, sampled on rising edges of the serial clock
   reg                      sclk_d;
   reg [`PIO_SHIFT_LEN-1:0] shreg;
   reg [`PIO_CNT_W-1:0]     bitcnt;
   reg                      sact_d;
   reg [`PIO_SHIFT_LEN-1:0] loaded;
   reg                      have_load;
   wire sclk_rise = sclk_s & ~sclk_d;
   wire load_done = sact_d & ~sact_s;

   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d    <= 1'b0;
         sact_d    <= 1'b0;
         shreg     <= {`PIO_SHIFT_LEN{1'b0}};
         bitcnt    <= {`PIO_CNT_W{1'b0}};
         loaded    <= {`PIO_SHIFT_LEN{1'b0}};
         have_load <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         sact_d <= sact_s;
         if (sact_s && !sact_d) begin
            bitcnt <= {`PIO_CNT_W{1'b0}};
         end else if (sact_s && sclk_rise) begin
            shreg <= {shreg[`PIO_SHIFT_LEN-2:0], sdat_s};
            if (bitcnt != `PIO_SHIFT_LEN)
               bitcnt <= bitcnt + 1'b1;
         end
         // A short frame is dropped whole; the old words stay
         if (load_done && bitcnt == `PIO_SHIFT_LEN) begin
            loaded    <= shreg;
            have_load <= 1'b1;
         end
      end
   end

   wire [15:0] ld_smw = loaded[`PIO_SMW_LSB +: `PIO_WORD_W];
   wire [15:0] ld_spw = loaded[`PIO_SPW_LSB +: `PIO_WORD_W];
   wire [15:0] smw    = (!pull_s || !have_load) ? BUILTIN_MAKER
                                                : ld_smw;

   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_maker_word           <= 16'h0000;
         o_subsystem_maker_word <= 16'h0000;
         o_subsystem_part_word  <= 16'h0000;
         o_part_nibble          <= 4'h0;
         o_target_retry         <= 1'b0;
         o_sequencer_pause      <= 1'b0;
         o_identity_copy_enable <= 1'b0;
         o_scan_mode            <= 1'b0;
         o_iddq_mode            <= 1'b0;
      end else begin
         o_subsystem_maker_word <= smw;
         o_subsystem_part_word  <= ld_spw;
         o_maker_word  <= copy_en ? smw : BUILTIN_MAKER;
         o_part_nibble <= copy_en ? ld_spw[`PIO_NIB_W-1:0]
                                  : BUILTIN_NIB;
         o_target_retry         <= sact_s;
         o_sequencer_pause      <= ~hold_s;
         o_identity_copy_enable <= copy_en;
         o_scan_mode            <= scan_m;
         o_iddq_mode            <= iddq_m;
      end
   end

   // TAP, stepped on rising TCK edges seen in the system clock.
   // TCK must run well below a quarter of the system clock.
   reg                 tck_d;
   reg [3:0]           tap;
   reg [3:0]           next_tap;
   reg [`PIO_IR_W-1:0] ir_sh;
   reg                 bypass;
   wire tck_rise = tck_s & ~tck_d;
   wire tck_fall = ~tck_s & tck_d;

   always @* begin
      next_tap = tap;
      case (tap)
         `PIO_TAP_RESET:  next_tap = tms_s ? `PIO_TAP_RESET  : `PIO_TAP_IDLE;
         `PIO_TAP_IDLE:   next_tap = tms_s ? `PIO_TAP_SEL_DR : `PIO_TAP_IDLE;
         `PIO_TAP_SEL_DR: next_tap = tms_s ? `PIO_TAP_SEL_IR : `PIO_TAP_CAP_DR;
         `PIO_TAP_CAP_DR: next_tap = tms_s ? `PIO_TAP_EX1_DR : `PIO_TAP_SH_DR;
         `PIO_TAP_SH_DR:  next_tap = tms_s ? `PIO_TAP_EX1_DR : `PIO_TAP_SH_DR;
         `PIO_TAP_EX1_DR: next_tap = tms_s ? `PIO_TAP_UPD_DR : `PIO_TAP_PAU_DR;
         `PIO_TAP_PAU_DR: next_tap = tms_s ? `PIO_TAP_EX2_DR : `PIO_TAP_PAU_DR;
         `PIO_TAP_EX2_DR: next_tap = tms_s ? `PIO_TAP_UPD_DR : `PIO_TAP_SH_DR;
         `PIO_TAP_UPD_DR: next_tap = tms_s ? `PIO_TAP_SEL_DR : `PIO_TAP_IDLE;
         `PIO_TAP_SEL_IR: next_tap = tms_s ? `PIO_TAP_RESET  : `PIO_TAP_CAP_IR;
         `PIO_TAP_CAP_IR: next_tap = tms_s ? `PIO_TAP_EX1_IR : `PIO_TAP_SH_IR;
         `PIO_TAP_SH_IR:  next_tap = tms_s ? `PIO_TAP_EX1_IR : `PIO_TAP_SH_IR;
         `PIO_TAP_EX1_IR: next_tap = tms_s ? `PIO_TAP_UPD_IR : `PIO_TAP_PAU_IR;
         `PIO_TAP_PAU_IR: next_tap = tms_s ? `PIO_TAP_EX2_IR : `PIO_TAP_PAU_IR;
         `PIO_TAP_EX2_IR: next_tap = tms_s ? `PIO_TAP_UPD_IR : `PIO_TAP_SH_IR;
         default:         next_tap = tms_s ? `PIO_TAP_SEL_DR : `PIO_TAP_IDLE;
      endcase
   end

   // Test reset acts on the third system clock edge after the pin falls, through the synchronised copy; the pin
   // itself is never used as an asynchronous reset to stay one domain.
   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tck_d  <= 1'b0;
         tap    <= `PIO_TAP_RESET;
         ir_sh  <= `PIO_IR_CAPTURE;
         bypass <= 1'b0;
         o_tdo  <= 1'b0;
      end else begin
         tck_d <= tck_s;
         if (!trst_s) begin
            tap    <= `PIO_TAP_RESET;
            ir_sh  <= `PIO_IR_CAPTURE;
            bypass <= 1'b0;
         end else if (tck_rise) begin
            tap <= next_tap;
            case (tap)
               `PIO_TAP_CAP_DR: bypass <= 1'b0;
               `PIO_TAP_SH_DR:  bypass <= tdi_s;
               `PIO_TAP_CAP_IR: ir_sh  <= `PIO_IR_CAPTURE;
               `PIO_TAP_SH_IR:  ir_sh  <= {tdi_s, ir_sh[`PIO_IR_W-1:1]};
               default:         bypass <= bypass;
            endcase
         end
         if (tck_fall) begin
            if (tap == `PIO_TAP_SH_DR)
               o_tdo <= bypass;
            else if (tap == `PIO_TAP_SH_IR)
               o_tdo <= ir_sh[0];
         end
      end
   end
endmodule

// *** tb/pio_top_properties.sv ***
// Checker for the identity loader and strap mode logic.
// Sees only top-level ports; bound into pio_top below.
`timescale 1ns/1ps
module pio_top_properties #(
   parameter [15:0] BUILTIN_MAKER = 16'h1234,
   parameter [3:0]  BUILTIN_NIB   = 4'hA
) (
   input wire        i_sys_clk,
   input wire        i_arst_n,
   input wire        i_test_strap_n,
   input wire        i_pull_disable_strap_n,
   input wire        i_serial_load_active,
   input wire        i_sequencer_hold_n,
   input wire [15:0] o_maker_word,
   input wire [15:0] o_subsystem_maker_word,
   input wire [15:0] o_subsystem_part_word,
   input wire [3:0]  o_part_nibble,
   input wire        o_target_retry,
   input wire        o_sequencer_pause,
   input wire        o_identity_copy_enable,
   input wire        o_scan_mode,
   input wire        o_iddq_mode
);
   // Outputs settle a few edges after reset release; count them off
   reg [3:0] up_cnt;
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         up_cnt <= 4'h0;
      else if (up_cnt != 4'hF)
         up_cnt <= up_cnt + 4'h1;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n || up_cnt < 4'h8);
   AST_COPY_MODE: assert property (o_identity_copy_enable ==
      ($past(i_test_strap_n, 3) && $past(i_pull_disable_strap_n, 3)))
      else $error("copy enable does not follow straps");
   AST_SCAN_MODE: assert property (o_scan_mode ==
      (!$past(i_test_strap_n, 3) && $past(i_pull_disable_strap_n, 3)))
      else $error("scan mode does not follow straps");
   AST_IDDQ_MODE: assert property (o_iddq_mode ==
      (!$past(i_test_strap_n, 3) && !$past(i_pull_disable_strap_n, 3)))
      else $error("quiescent mode does not follow straps");
   AST_PAUSE: assert property (o_sequencer_pause ==
      !$past(i_sequencer_hold_n, 3))
      else $error("pause does not follow hold input");
   AST_RETRY: assert property (o_target_retry ==
      $past(i_serial_load_active, 3))
      else $error("retry does not follow load activity");
   AST_MAKER_COPY: assert property (o_identity_copy_enable &&
      $past(o_identity_copy_enable) && $stable(o_subsystem_maker_word)
      |-> o_maker_word == o_subsystem_maker_word)
      else $error("maker word not copied");
   AST_BUILTIN: assert property (!i_pull_disable_strap_n [*6] |->
      o_subsystem_maker_word == BUILTIN_MAKER &&
      o_maker_word == BUILTIN_MAKER && o_part_nibble == BUILTIN_NIB)
      else $error("built-in words not forced");
   AST_NO_PARTIAL: assert property (i_serial_load_active [*5] |->
      $stable(o_subsystem_part_word) && $stable(o_subsystem_maker_word))
      else $error("words changed during a load");
   AST_NIBBLE: assert property (o_identity_copy_enable &&
      $past(o_identity_copy_enable) && $stable(o_subsystem_part_word)
      |-> o_part_nibble == o_subsystem_part_word[3:0])
      else $error("part nibble not copied");
endmodule
bind pio_top pio_top_properties #(.BUILTIN_MAKER(BUILTIN_MAKER),
   .BUILTIN_NIB(BUILTIN_NIB)) chk_u (.i_sys_clk(i_sys_clk),
   .i_arst_n(i_arst_n), .i_test_strap_n(i_test_strap_n),
   .i_pull_disable_strap_n(i_pull_disable_strap_n),
   .i_serial_load_active(i_serial_load_active),
   .i_sequencer_hold_n(i_sequencer_hold_n), .o_maker_word(o_maker_word),
   .o_subsystem_maker_word(o_subsystem_maker_word),
   .o_subsystem_part_word(o_subsystem_part_word),
   .o_part_nibble(o_part_nibble), .o_target_retry(o_target_retry),
   .o_sequencer_pause(o_sequencer_pause),
   .o_identity_copy_enable(o_identity_copy_enable),
   .o_scan_mode(o_scan_mode), .o_iddq_mode(o_iddq_mode));

// *** tb/pio_serial_src.sv ***
// Serial identity source model: frame, bit clock and data, MSB first.
// Assumes the caller starts a frame only after reset has settled.
`timescale 1ns/1ps
module pio_serial_src (
   input  wire  i_clk,
   output logic o_data,
   output logic o_bit_clk,
   output logic o_active
);
   initial begin
      o_data = 1'b0;
      o_bit_clk = 1'b0;
      o_active = 1'b0;
   end
   // Each bit clock level lasts two system clocks; bit clock idles low
   task send(input logic [32:0] word, input int nbits);
      @(posedge i_clk) o_active <= 1'b1;
      for (int i = nbits - 1; i >= 0; i--) begin
         o_data <= word[i];
         repeat (2) @(posedge i_clk);
         o_bit_clk <= 1'b1;
         repeat (2) @(posedge i_clk);
         o_bit_clk <= 1'b0;
      end
      repeat (2) @(posedge i_clk);
      o_active <= 1'b0;
      // Released line shows the inverse rather than a stale bit
      o_data <= ~o_data;
   endtask
endmodule

// *** tb/tb_top.sv ***
// Testbench for pio_top: serial loads, straps, hold and TAP bypass.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
   fail_count++; $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   localparam [15:0] MAKER = 16'h1234;
   localparam [3:0]  NIB   = 4'hA;
   logic clk = 1'b0, arst_n = 1'b0, tst_n = 1'b1, pull_n = 1'b1;
   logic hold_n = 1'b1, tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_n = 1'b0;
   wire sdat, sclk, sact, retry, pause, copy, scan, iddq, tdo;
   wire [15:0] maker, smaker, spart;
   wire [3:0] nib;
   int fail_count = 0, check_count = 0;
   always #20 clk = ~clk;
   pio_serial_src src_u (.i_clk(clk), .o_data(sdat), .o_bit_clk(sclk),
      .o_active(sact));
   pio_top #(.BUILTIN_MAKER(MAKER), .BUILTIN_NIB(NIB)) dut_u (
      .i_sys_clk(clk), .i_arst_n(arst_n), .i_test_strap_n(tst_n),
      .i_pull_disable_strap_n(pull_n), .i_serial_identity_input(sdat),
      .i_serial_clock(sclk), .i_serial_load_active(sact),
      .i_sequencer_hold_n(hold_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .i_trst_n(trst_n), .o_maker_word(maker),
      .o_subsystem_maker_word(smaker), .o_subsystem_part_word(spart),
      .o_part_nibble(nib), .o_target_retry(retry),
      .o_sequencer_pause(pause), .o_identity_copy_enable(copy),
      .o_scan_mode(scan), .o_iddq_mode(iddq), .o_tdo(tdo));
   task end_of_test;
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One TCK period, TCK high for three system clocks, then low for ten including sync settle
   task tap(input logic ms, input logic di);
      @(posedge clk) begin tms <= ms; tdi <= di; end
      wait_clk(2);
      @(posedge clk) tck <= 1'b1;
      wait_clk(2);
      @(posedge clk) tck <= 1'b0;
      wait_clk(6);
   endtask
   initial begin
      wait_clk(20000);
      fail_count++;
      end_of_test;
   end
   initial begin
      wait_clk(4);
      @(posedge clk) begin arst_n <= 1'b1; trst_n <= 1'b1; end
      wait_clk(10);
      `CHK(smaker, MAKER)
      fork
         src_u.send({1'b1, 16'h5A3C, 16'hC0DE}, 33);
         begin wait_clk(20); `CHK(retry, 1'b1) end
      join
      wait_clk(8);
      `CHK(smaker, 16'hC0DE)
      `CHK(spart, 16'h5A3C)
      `CHK(maker, 16'hC0DE)
      `CHK(nib, 4'hC)
      `CHK(retry, 1'b0)
      src_u.send({1'b0, 16'h0F0F, 16'h7777}, 32);
      wait_clk(8);
      `CHK(smaker, 16'hC0DE)
      `CHK(spart, 16'h5A3C)
      @(posedge clk) hold_n <= 1'b0;
      wait_clk(5);
      `CHK(pause, 1'b1)
      @(posedge clk) hold_n <= 1'b1;
      wait_clk(5);
      `CHK(pause, 1'b0)
      repeat (5) tap(1'b1, 1'b0);
      tap(1'b0, 1'b0);
      tap(1'b1, 1'b0);
      tap(1'b0, 1'b0);
      tap(1'b0, 1'b1);
      `CHK(tdo, 1'b0)
      tap(1'b0, 1'b1);
      `CHK(tdo, 1'b1)
      tap(1'b0, 1'b0);
      `CHK(tdo, 1'b0)
      @(posedge clk) trst_n <= 1'b0;
      wait_clk(5);
      @(posedge clk) trst_n <= 1'b1;
      wait_clk(5);
      tap(1'b0, 1'b1);
      `CHK(tdo, 1'b0)
      for (int c = 0; c < 4; c++) begin
         @(posedge clk) begin tst_n <= c[1]; pull_n <= c[0]; end
         wait_clk(8);
         `CHK(copy, c == 3)
         `CHK(scan, c == 1)
         `CHK(iddq, c == 0)
         if (c != 3) begin
            `CHK(maker, MAKER)
            `CHK(nib, NIB)
         end
         if (c[0] == 1'b0)
            `CHK(smaker, MAKER)
      end
      end_of_test;
   end
endmodule
